/* design/uscf_pkg.sv */
/*
 * uscf_pkg: constants shared by the serial port control flag block.
 * assumes a single 125 mhz system clock and a byte-wide register port.
 */
package uscf_pkg;
    // ========================================================
    // register map
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_IRQ_STATUS = 2'h2;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;
    // ========================================================
    // control register fields
    localparam int BIT_RX_DONE = 0;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_RX_NINTH = 2;
    localparam int BIT_TX_NINTH = 3;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_MULTIPROC = 5;
    localparam int BIT_NINE_BIT = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // interrupt status bits
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    // ========================================================
    // timing
    localparam int CLK_HZ = 125000000;
    localparam int BAUD = 115200;
    localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD);
    localparam logic [15:0] HALF_CYCLES = 16'(CLK_HZ / BAUD / 2);
    localparam int STREAM_BITS = 12;
endpackage

/* design/uscf_bit_timer.sv */
/*
 * uscf_bit_timer: bit period divider giving one-cycle enable pulses.
 * assumes the start input is a one-cycle pulse on mclk.
 */
`timescale 1ns/1ps
module uscf_bit_timer (
    input wire logic mclk,
    input wire logic reset,
    input wire logic run,
    input wire logic restart_half,
    output logic tick
);
    import uscf_pkg::*;
    logic [15:0] count;

    // ========================================================
    // divider: restart_half loads half a bit so ticks land mid bit
    always_ff @(posedge mclk) begin
        // restart outranks the idle reload: the receiver arms the timer while still idle
        if (reset) begin
            count <= BIT_CYCLES - 16'h0001;
            tick <= 1'b0;
        end else if (restart_half) begin
            count <= HALF_CYCLES - 16'h0001;
            tick <= 1'b0;
        end else if (!run) begin
            count <= BIT_CYCLES - 16'h0001;
            tick <= 1'b0;
        end else if (count == 16'h0000) begin
            count <= BIT_CYCLES - 16'h0001;
            tick <= 1'b1;
        end else begin
            count <= count - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

/* design/uscf_top.sv */
/*
 * uscf_top: serial port control and status flags with a minimal frame engine.
 * assumes a cpu on a plain strobe port on mclk; rxd arrives asynchronously.
 */
// The address map and the strobed register port are this design's own decisions.
// Overview of operation
// - mp 9-bit: flag only when ninth bit 1
// - rx enable bit 4 gates receiver
// - 9-bit sends tx ninth bit; 8-bit ignores
// - rx ninth bit: stop bit or ninth bit
// - tx done after bit 8 / at stop
// - set tx done requests interrupt
// - tx done cleared only by software
// - rx done set at stop sampling
// - rx done interrupts, held until cleared
// - mp off: ninth bit level ignored
// - 8-bit mp: flag only if stop 1
`timescale 1ns/1ps
module uscf_top (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic rxd,
    output logic txd,
    output logic irq
);
    import uscf_pkg::*;

    typedef enum {TX_IDLE, TX_SHIFT} uscf_tx_state_t;
    typedef enum {RX_IDLE, RX_START, RX_SHIFT} uscf_rx_state_t;

    logic [7:0] serial_port_control;
    logic [7:0] irq_mask;
    logic [7:0] rx_data;
    logic [1:0] irq_status;
    logic rxd_meta, rxd_sync;
    uscf_tx_state_t tx_state;
    uscf_rx_state_t rx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_count, rx_count;
    logic [8:0] rx_shift;
    logic tx_tick, rx_tick, rx_restart;
    logic tx_done_set, rx_done_set, rx_frame_end;
    logic nine_bit, rx_accept;
    logic [3:0] tx_last, rx_last;

    function automatic logic wr_hit(input logic [1:0] a);
        return wr_en && addr == a;
    endfunction

    assign nine_bit = serial_port_control[BIT_NINE_BIT];
    assign tx_last = nine_bit ? 4'ha : 4'h9;
    assign rx_last = nine_bit ? 4'h9 : 4'h8;

    // ========================================================
    // input synchroniser
    always_ff @(posedge mclk) begin
        if (reset) begin
            rxd_meta <= 1'b1;
            rxd_sync <= 1'b1;
        end else begin
            rxd_meta <= rxd;
            rxd_sync <= rxd_meta;
        end
    end

    // ========================================================
    // transmitter: a data write starts a frame
    uscf_bit_timer u_tx_timer (
        .mclk(mclk),
        .reset(reset),
        .run(tx_state == TX_SHIFT),
        .restart_half(1'b0),
        .tick(tx_tick)
    );

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_state <= TX_IDLE;
            tx_shift <= 11'h7ff;
            tx_count <= 4'h0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (wr_hit(ADDR_DATA)) begin
                        // frame lsb first: start, data, ninth (9-bit only), stop
                        if (nine_bit) begin
                            tx_shift <= {1'b1, serial_port_control[BIT_TX_NINTH], wdata,
                                1'b0};
                        end else begin
                            tx_shift <= {2'b11, wdata, 1'b0};
                        end
                        tx_count <= 4'h0;
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_tick) begin
                        tx_shift <= {1'b1, tx_shift[10:1]};
                        tx_count <= tx_count + 4'h1;
                        if (tx_count == tx_last) begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            txd <= 1'b1;
        end else begin
            txd <= (tx_state == TX_SHIFT) ? tx_shift[0] : 1'b1;
        end
    end

    // tick ending bit 8 data (8-bit) or ninth bit, i.e. stop bit begins
    assign tx_done_set = tx_state == TX_SHIFT && tx_tick
        && tx_count == (tx_last - 4'h1);

    // ========================================================
    // receiver
    uscf_bit_timer u_rx_timer (
        .mclk(mclk),
        .reset(reset),
        .run(rx_state != RX_IDLE),
        .restart_half(rx_restart),
        .tick(rx_tick)
    );

    assign rx_restart = rx_state == RX_IDLE && !rxd_sync
        && serial_port_control[BIT_RX_ENABLE];

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_state <= RX_IDLE;
            rx_shift <= 9'h000;
            rx_count <= 4'h0;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (rx_restart) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        // a start glitch back to high is dropped
                        rx_state <= rxd_sync ? RX_IDLE : RX_SHIFT;
                        rx_count <= 4'h0;
                    end
                end
                RX_SHIFT: begin
                    if (rx_tick) begin
                        rx_shift <= {rxd_sync, rx_shift[8:1]};
                        rx_count <= rx_count + 4'h1;
                        if (rx_count == rx_last) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // stop bit sampled now in both modes; in 9-bit mode the ninth bit was sampled one tick earlier
    assign rx_frame_end = rx_state == RX_SHIFT && rx_tick && rx_count == rx_last;
    // sampled value rxd_sync is the stop bit (8-bit) or the stop of 9-bit frame
    // in 9-bit mode the ninth bit is rx_shift[8] at this edge
    assign rx_accept = !serial_port_control[BIT_MULTIPROC]
        || (nine_bit ? rx_shift[8] : rxd_sync);
    assign rx_done_set = rx_frame_end && rx_accept
        && serial_port_control[BIT_RX_ENABLE];

    // ========================================================
    // control register: set beats software clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            serial_port_control <= CONTROL_RESET;
        end else begin
            if (wr_hit(ADDR_CONTROL)) begin
                serial_port_control <= wdata;
            end
            if (tx_done_set) begin
                serial_port_control[BIT_TX_DONE] <= 1'b1;
            end
            if (rx_done_set) begin
                serial_port_control[BIT_RX_DONE] <= 1'b1;
                serial_port_control[BIT_RX_NINTH] <= nine_bit ? rx_shift[8] : rxd_sync;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_data <= 8'h00;
        end else if (rx_done_set) begin
            rx_data <= nine_bit ? rx_shift[7:0] : rx_shift[8:1];
        end
    end

    // ========================================================
    // interrupt status: sticky, write one to clear, set wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_status <= 2'h0;
        end else begin
            if (wr_hit(ADDR_IRQ_STATUS)) begin
                irq_status <= irq_status & ~wdata[1:0];
            end
            if (tx_done_set) begin
                irq_status[IRQ_TX] <= 1'b1;
            end
            if (rx_done_set) begin
                irq_status[IRQ_RX] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_mask <= MASK_RESET;
        end else if (wr_hit(ADDR_IRQ_MASK)) begin
            irq_mask <= wdata;
        end
    end

    // line follows the live flags so it drops once software clears them
    assign irq = |(irq_status & irq_mask[1:0]
        & {serial_port_control[BIT_TX_DONE], serial_port_control[BIT_RX_DONE]});

    // ========================================================
    // read port
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            if (addr == ADDR_CONTROL) begin
                rdata <= serial_port_control;
            end else if (addr == ADDR_DATA) begin
                rdata <= rx_data;
            end else if (addr == ADDR_IRQ_STATUS) begin
                rdata <= {6'h00, irq_status};
            end else begin
                rdata <= irq_mask;
            end
        end else begin
            rdata <= 8'h00;
        end
    end

    // ========================================================
    // checks
    property p_tx_sticky;
        @(posedge mclk) disable iff (reset)
        $fell(serial_port_control[BIT_TX_DONE]) |-> $past(wr_en) && $past(addr) == ADDR_CONTROL;
    endproperty
    a_tx_sticky: assert property (p_tx_sticky) else $error("tx done cleared by hw");

    property p_rx_sticky;
        @(posedge mclk) disable iff (reset)
        $fell(serial_port_control[BIT_RX_DONE]) |-> $past(wr_en) && $past(addr) == ADDR_CONTROL;
    endproperty
    a_rx_sticky: assert property (p_rx_sticky) else $error("rx done cleared by hw");

    property p_tx_set;
        @(posedge mclk) disable iff (reset)
        tx_done_set |=> serial_port_control[BIT_TX_DONE] ##0 irq_status[IRQ_TX];
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx done not set");

    property p_rx_set;
        @(posedge mclk) disable iff (reset)
        rx_done_set |=> serial_port_control[BIT_RX_DONE];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx done not set");

    property p_mp_filter;
        @(posedge mclk) disable iff (reset)
        rx_frame_end && serial_port_control[BIT_MULTIPROC] && nine_bit && !rx_shift[8]
            |-> !rx_done_set;
    endproperty
    a_mp_filter: assert property (p_mp_filter) else $error("mp frame flagged");

    property p_mp_stop;
        @(posedge mclk) disable iff (reset)
        rx_frame_end && serial_port_control[BIT_MULTIPROC] && !nine_bit && !rxd_sync
            |-> !rx_done_set;
    endproperty
    a_mp_stop: assert property (p_mp_stop) else $error("bad stop flagged");

    property p_rx_off;
        @(posedge mclk) disable iff (reset)
        !serial_port_control[BIT_RX_ENABLE] && rx_state == RX_IDLE |=> rx_state == RX_IDLE;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receiver ran while off");

    property p_irq;
        @(posedge mclk) disable iff (reset)
        serial_port_control[BIT_TX_DONE] && irq_status[IRQ_TX] && irq_mask[IRQ_TX] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_no_mp;
        @(posedge mclk) disable iff (reset)
        rx_frame_end && !serial_port_control[BIT_MULTIPROC]
            && serial_port_control[BIT_RX_ENABLE] |-> rx_done_set;
    endproperty
    a_no_mp: assert property (p_no_mp) else $error("frame dropped");

    c_tx: cover property (@(posedge mclk) tx_done_set);
    c_rx: cover property (@(posedge mclk) rx_done_set && nine_bit);
    c_irq: cover property (@(posedge mclk) $rose(irq));
endmodule

/* tb/uscf_node.sv */
/*
 * uscf_node: remote serial node that sends frames to the block and samples its frames.
 * assumes uscf_pkg bit timing; frames are built by the caller, start bit first.
 */
`timescale 1ns/1ps
module uscf_node (
    input wire logic mclk,
    input wire logic txd,
    output logic rxd
);
    import uscf_pkg::*;
    logic [10:0] got;
    int idx;
    // idle line sits high, as a pulled-up line would
    initial begin
        rxd = 1'b1;
        idx = -1;
    end
    // ========================================================
    // transmit towards the block
    task automatic send(input logic [10:0] frame, input int n);
        @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            rxd <= frame[i];
            repeat (BIT_CYCLES) @(posedge mclk);
        end
        rxd <= 1'b1;
    endtask
    // ========================================================
    // sample the block's frame mid-bit; idx lets the bench time its reads
    task automatic capture(input int n);
        got = '1;
        idx = -1;
        @(negedge txd);
        repeat (HALF_CYCLES) @(posedge mclk);
        for (int i = 0; i < n; i++) begin
            got[i] = txd;
            idx = i;
            if (i < n - 1) begin
                repeat (BIT_CYCLES) @(posedge mclk);
            end
        end
    endtask
endmodule

/* tb/tb_uscf_top.sv */
/*
 * tb_uscf_top: self-checking bench for the serial port control flags.
 * assumes uscf_top on the strobe register port and uscf_node on the serial lines.
 */
`timescale 1ns/1ps
module tb_uscf_top;
    import uscf_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] v;
    logic txd;
    logic rxd;
    logic irq;
    int n_mismatch = 0;
    int n_compared = 0;
    always #4 mclk = ~mclk;
    uscf_top i_dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd), .irq(irq));
    uscf_node i_node (.mclk(mclk), .txd(txd), .rxd(rxd));
    // ========================================================
    // bus cycles and comparison
    task automatic check(input logic [10:0] seen, input logic [10:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge mclk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge mclk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge mclk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ========================================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a < 4; a++) begin
            rd(2'(a));
            check(v, 8'h00);
        end
        check(irq, 1'b0);
        check(txd, 1'b1);
    endtask
    // tx done must be clear mid bit l-1 and set mid bit l
    // tn is the ninth bit to send; 8-bit mode ignores it and bit 9 is still the stop bit
    task automatic t_tx(input logic nine, input logic tn, input logic [7:0] d);
        int l;
        l = nine ? 10 : 9;
        wr(ADDR_IRQ_MASK, 8'h02);
        wr(ADDR_CONTROL, {nine, 3'b000, tn, 3'b000});
        fork
            i_node.capture(l + 1);
            begin
                wr(ADDR_DATA, d);
                wait (i_node.idx == l - 1);
                rd(ADDR_CONTROL);
                check(v[BIT_TX_DONE], 1'b0);
                wait (i_node.idx == l);
                rd(ADDR_CONTROL);
                check(v[BIT_TX_DONE], 1'b1);
                check(irq, 1'b1);
            end
        join
        check(i_node.got, {1'b1, nine ? tn : 1'b1, d, 1'b0});
        // the frame must be over before the next scenario rewrites the mode
        repeat (BIT_CYCLES) @(posedge mclk);
        rd(ADDR_CONTROL);
        check(v[BIT_TX_DONE], 1'b1);
        wr(ADDR_IRQ_STATUS, 8'h02);
        wr(ADDR_CONTROL, 8'h00);
        check(irq, 1'b0);
        rd(ADDR_CONTROL);
        check(v[BIT_TX_DONE], 1'b0);
    endtask
    // irq is first masked, then unmasked, then cleared through both flags
    task automatic t_rx(input logic [7:0] ctl, input logic [10:0] f, input int n,
            input logic done, input logic ninth);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CONTROL, ctl);
        i_node.send(f, n);
        // stop is sampled mid bit, so the flags are settled before send returns
        repeat (4) @(posedge mclk);
        rd(ADDR_CONTROL);
        check(v[BIT_RX_DONE], done);
        if (done || !ctl[BIT_RX_ENABLE]) begin
            check(v[BIT_RX_NINTH], ninth);
        end
        check(irq, 1'b0);
        wr(ADDR_IRQ_MASK, 8'h01);
        check(irq, done);
        if (done) begin
            rd(ADDR_DATA);
            check(v, f[8:1]);
        end
        wr(ADDR_IRQ_STATUS, 8'h01);
        wr(ADDR_CONTROL, ctl);
        check(irq, 1'b0);
    endtask
    // ========================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_tx(1'b0, 1'b0, 8'ha5);
        t_tx(1'b1, 1'b0, 8'h96);
        t_rx(8'h30, {2'b11, 8'h3c, 1'b0}, 10, 1'b1, 1'b1);
        t_rx(8'h30, {2'b10, 8'hc3, 1'b0}, 10, 1'b0, 1'b0);
        t_rx(8'hb0, {2'b10, 8'h5a, 1'b0}, 11, 1'b0, 1'b0);
        t_rx(8'hb0, {2'b11, 8'ha5, 1'b0}, 11, 1'b1, 1'b1);
        t_rx(8'h90, {2'b10, 8'h0f, 1'b0}, 11, 1'b1, 1'b0);
        t_rx(8'h84, {2'b10, 8'hf0, 1'b0}, 11, 1'b0, 1'b1);
        report_and_stop();
    end
    // eight frames come to about 93,500 cycles with bus traffic; small margin
    initial begin
        repeat (99000) @(posedge mclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule
